// [hw/apcm_pkg.sv]
package apcm_pkg;

    // Number of shared address / port pins handled here.
    localparam int unsigned PIN_COUNT = 6;

    // Port A index of the lowest shared pin (address line zero).
    localparam int unsigned PORT_A_FIRST = 8;

    // Port A index of the highest shared pin (address line five).
    localparam int unsigned PORT_A_LAST = 13;

    // Number of external bus control outputs gated by the idle policy.
    localparam int unsigned CTRL_COUNT = 3;

    // Width of the clock-output select field.
    localparam int unsigned CLOCK_OUT_PIN_SEL_W = 4;

    // Clock-output select codes.
    localparam logic [3:0] CLOCK_OUT_PIN_OFF = 4'h0;
    localparam logic [3:0] CLOCK_OUT_PIN_MASTER = 4'h1;
    localparam logic [3:0] CLOCK_OUT_PIN_PERIPH = 4'h2;
    localparam logic [3:0] CLOCK_OUT_PIN_OSC = 4'h3;
    localparam logic [3:0] CLOCK_OUT_PIN_PRESCALE = 4'h4;
    localparam logic [3:0] CLOCK_OUT_PIN_POSTSCALE = 4'h5;
    localparam logic [3:0] CLOCK_OUT_PIN_TEST0 = 4'h6;
    localparam logic [3:0] CLOCK_OUT_PIN_TEST1 = 4'h7;

    // Reset values and all-on patterns of the pin controls.
    localparam logic [5:0] PIN_OE_RESET = 6'h00;
    localparam logic [5:0] PIN_PU_RESET = 6'h3f;
    localparam logic [5:0] PIN_OUT_RESET = 6'h00;
    localparam logic [5:0] PIN_ALL_ON = 6'h3f;
    localparam logic [2:0] CTRL_OE_RESET = 3'h0;
    localparam logic [2:0] CTRL_OUT_RESET = 3'h7;
    localparam logic [2:0] CTRL_ALL_ON = 3'h7;

    // Clock-input mode pin values.
    localparam logic CLKIN_EXTERNAL = 1'b1;
    localparam logic CLKIN_CRYSTAL = 1'b0;

endpackage : apcm_pkg

// [hw/apcm_clk_sel.sv]
module apcm_clk_sel
    import apcm_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic resetn,
    // Selection.
    input wire logic [apcm_pkg::CLOCK_OUT_PIN_SEL_W-1:0] clock_out_select_reg,
    // Candidate sources.
    input wire logic master_system_clock,
    input wire logic peripheral_bus_clock,
    input wire logic osc_out,
    input wire logic prescaler_clk,
    input wire logic postscaler_clk,
    input wire logic [1:0] test_sig,
    // Clock output pin.
    output logic clock_out_pin,
    output logic clock_out_oe
);

    logic src_w;
    logic en_w;

    // Source decode; unknown codes behave as off.
    assign src_w = (clock_out_select_reg == CLOCK_OUT_PIN_MASTER) ? master_system_clock :
                   (clock_out_select_reg == CLOCK_OUT_PIN_PERIPH) ? peripheral_bus_clock :
                   (clock_out_select_reg == CLOCK_OUT_PIN_OSC) ? osc_out :
                   (clock_out_select_reg == CLOCK_OUT_PIN_PRESCALE) ? prescaler_clk :
                   (clock_out_select_reg == CLOCK_OUT_PIN_POSTSCALE) ? postscaler_clk :
                   (clock_out_select_reg == CLOCK_OUT_PIN_TEST0) ? test_sig[0] :
                   (clock_out_select_reg == CLOCK_OUT_PIN_TEST1) ? test_sig[1] : 1'b0;
    assign en_w = (clock_out_select_reg != CLOCK_OUT_PIN_OFF) &&
                  (clock_out_select_reg <= CLOCK_OUT_PIN_TEST1);

    // Output buffer stage; the driver stays off throughout reset.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            clock_out_pin <= 1'b0;
            clock_out_oe <= 1'b0;
        end else begin
            clock_out_pin <= src_w;
            clock_out_oe <= en_w;
        end
    end

    property p_clock_out_pin_off;
        @(posedge ref_clk) disable iff (!resetn)
        clock_out_select_reg == CLOCK_OUT_PIN_OFF |=> !clock_out_oe && !clock_out_pin;
    endproperty
    a_clock_out_pin_off: assert property (p_clock_out_pin_off) else $error("Clock out not off.");

    property p_clock_out_pin_master;
        @(posedge ref_clk) disable iff (!resetn)
        clock_out_select_reg == CLOCK_OUT_PIN_MASTER |=>
            clock_out_oe && clock_out_pin == $past(master_system_clock);
    endproperty
    a_clock_out_pin_master: assert property (p_clock_out_pin_master) else $error("Master clock not out.");

    property p_clock_out_pin_post;
        @(posedge ref_clk) disable iff (!resetn)
        clock_out_select_reg == CLOCK_OUT_PIN_POSTSCALE |=> clock_out_pin == $past(postscaler_clk);
    endproperty
    a_clock_out_pin_post: assert property (p_clock_out_pin_post) else $error("Postscaler not out.");

    property p_clock_out_pin_reset;
        @(posedge ref_clk) disable iff (!resetn)
        $rose(resetn) |-> !clock_out_oe;
    endproperty
    a_clock_out_pin_reset: assert property (p_clock_out_pin_reset) else $error("Clock out driven in reset.");

endmodule : apcm_clk_sel

// [hw/apcm_top.sv]
// Functional notes
// - Shared pins start in address-bus role.
// - Carry address 0..5; reset: drivers off, pull-ups.
// - Idle bus tri-states or drives per idle bit.
// - Port mode: each pin independently input/output.
// - Cleared pull-up register bit disables pull-up.
// - Clock output emits selected buffered clock.
// - Clock output driver off during reset.
// - Input clock feeds core or PLL reference.
// - Mode pin: 1 external clock, 0 crystal.
module apcm_top
    import apcm_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic resetn,
    // External memory interface side.
    input wire logic [apcm_pkg::PIN_COUNT-1:0] emi_addr,
    input wire logic [apcm_pkg::CTRL_COUNT-1:0] emi_ctrl,
    input wire logic emi_bus_active,
    input wire logic bus_idle_drive_bit,
    // Port A side.
    input wire logic [apcm_pkg::PIN_COUNT-1:0] port_sel,
    input wire logic [apcm_pkg::PIN_COUNT-1:0] port_dir,
    input wire logic [apcm_pkg::PIN_COUNT-1:0] port_out,
    input wire logic [apcm_pkg::PORT_A_LAST:apcm_pkg::PORT_A_FIRST] port_a_pullup_enable_reg,
    output logic [apcm_pkg::PIN_COUNT-1:0] port_in,
    // Shared address pins.
    input wire logic [apcm_pkg::PIN_COUNT-1:0] addr_pin_i,
    output logic [apcm_pkg::PIN_COUNT-1:0] addr_pin_o,
    output logic [apcm_pkg::PIN_COUNT-1:0] addr_pin_oe,
    output logic [apcm_pkg::PIN_COUNT-1:0] addr_pin_pu,
    // External bus control pins.
    output logic [apcm_pkg::CTRL_COUNT-1:0] ctrl_pin_o,
    output logic [apcm_pkg::CTRL_COUNT-1:0] ctrl_pin_oe,
    // Clock output selection and sources.
    input wire logic [apcm_pkg::CLOCK_OUT_PIN_SEL_W-1:0] clock_out_select_reg,
    input wire logic master_system_clock,
    input wire logic peripheral_bus_clock,
    input wire logic osc_out,
    input wire logic prescaler_clk,
    input wire logic postscaler_clk,
    input wire logic [1:0] test_sig,
    output logic clock_out_pin,
    output logic clock_out_oe,
    // Input clock routing.
    input wire logic clock_input_select_pin,
    input wire logic crystal_in_pin,
    input wire logic crystal_out_pin_i,
    input wire logic pll_ref_sel,
    input wire logic pll_clk,
    output logic osc_amp_en,
    output logic core_clk_src,
    output logic pll_ref_clk
);

    logic addr_drive_w;
    logic [PIN_COUNT-1:0] pin_o_d;
    logic [PIN_COUNT-1:0] pin_oe_d;
    logic [PIN_COUNT-1:0] pin_pu_d;
    logic [CTRL_COUNT-1:0] ctrl_oe_d;
    logic input_clk_w;
    logic core_clk_d;
    logic pll_ref_d;

    // Address drivers run while the bus is busy, or when idle with drive held on.
    assign addr_drive_w = emi_bus_active || bus_idle_drive_bit;
    assign ctrl_oe_d = addr_drive_w ? CTRL_ALL_ON : CTRL_OE_RESET;

    // Per-pin selection between the address role and the port role.
    generate
        for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
            // The address role drives the address, with enable set by the idle policy, until software selects the port role.
            assign pin_o_d[i] = port_sel[i] ? port_out[i] : emi_addr[i];
            assign pin_oe_d[i] = port_sel[i] ? port_dir[i] : addr_drive_w;
            // Pull-up bit index matches the port pin index.
            assign pin_pu_d[i] = port_a_pullup_enable_reg[PORT_A_FIRST + i];
        end
    endgenerate

    // Pin control registers; reset leaves drivers off and pull-ups on.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            addr_pin_o <= PIN_OUT_RESET;
            addr_pin_oe <= PIN_OE_RESET;
            addr_pin_pu <= PIN_PU_RESET;
        end else begin
            addr_pin_o <= pin_o_d;
            addr_pin_oe <= pin_oe_d;
            addr_pin_pu <= pin_pu_d;
        end
    end

    // Control pins follow the same idle policy as the address pins.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_pin_o <= CTRL_OUT_RESET;
            ctrl_pin_oe <= CTRL_OE_RESET;
        end else begin
            ctrl_pin_o <= emi_ctrl;
            ctrl_pin_oe <= ctrl_oe_d;
        end
    end

    // Pin levels returned to the port, captured every cycle.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            port_in <= PIN_OUT_RESET;
        end else begin
            port_in <= addr_pin_i;
        end
    end

    // Input clock: external clock on the crystal output pin, else the oscillator.
    assign input_clk_w = (clock_input_select_pin == CLKIN_EXTERNAL) ?
                         crystal_out_pin_i : crystal_in_pin;
    assign core_clk_d = pll_ref_sel ? pll_clk : input_clk_w;
    assign pll_ref_d = pll_ref_sel ? input_clk_w : 1'b0;

    // Clock routing registers; the amplifier runs only in crystal mode.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            osc_amp_en <= 1'b0;
            core_clk_src <= 1'b0;
            pll_ref_clk <= 1'b0;
        end else begin
            osc_amp_en <= (clock_input_select_pin == CLKIN_CRYSTAL);
            core_clk_src <= core_clk_d;
            pll_ref_clk <= pll_ref_d;
        end
    end

    // Clock output selector and pin buffer.
    apcm_clk_sel u_clk_sel (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .clock_out_select_reg(clock_out_select_reg),
        .master_system_clock(master_system_clock),
        .peripheral_bus_clock(peripheral_bus_clock),
        .osc_out(osc_out),
        .prescaler_clk(prescaler_clk),
        .postscaler_clk(postscaler_clk),
        .test_sig(test_sig),
        .clock_out_pin(clock_out_pin),
        .clock_out_oe(clock_out_oe)
    );

    property p_addr_role;
        @(posedge ref_clk) disable iff (!resetn)
        port_sel == 6'h00 && emi_bus_active |=>
            addr_pin_oe == PIN_ALL_ON && addr_pin_o == $past(emi_addr);
    endproperty
    a_addr_role: assert property (p_addr_role) else $error("Address role not driven.");

    property p_reset_state;
        @(posedge ref_clk) disable iff (!resetn)
        $rose(resetn) |-> addr_pin_oe == PIN_OE_RESET && addr_pin_pu == PIN_PU_RESET;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("Pins wrong in reset.");

    property p_idle_float;
        @(posedge ref_clk) disable iff (!resetn)
        !emi_bus_active && !bus_idle_drive_bit && port_sel == 6'h00 |=>
            addr_pin_oe == PIN_OE_RESET && ctrl_pin_oe == CTRL_OE_RESET;
    endproperty
    a_idle_float: assert property (p_idle_float) else $error("Idle bus not floated.");

    property p_idle_hold;
        @(posedge ref_clk) disable iff (!resetn)
        !emi_bus_active && bus_idle_drive_bit && port_sel == 6'h00 |=>
            addr_pin_oe == PIN_ALL_ON && ctrl_pin_oe == CTRL_ALL_ON;
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("Idle bus not driven.");

    property p_port_mode;
        @(posedge ref_clk) disable iff (!resetn)
        port_sel == 6'h3f |=>
            addr_pin_oe == $past(port_dir) && addr_pin_o == $past(port_out);
    endproperty
    a_port_mode: assert property (p_port_mode) else $error("Port mode mismatch.");

    property p_pullup;
        @(posedge ref_clk) disable iff (!resetn)
        !port_a_pullup_enable_reg[PORT_A_FIRST] |=> !addr_pin_pu[0];
    endproperty
    a_pullup: assert property (p_pullup) else $error("Pull-up not disabled.");

    property p_clk_mode;
        @(posedge ref_clk) disable iff (!resetn)
        clock_input_select_pin && !pll_ref_sel |=>
            core_clk_src == $past(crystal_out_pin_i) && !osc_amp_en;
    endproperty
    a_clk_mode: assert property (p_clk_mode) else $error("External clock not used.");

    property p_pll_ref;
        @(posedge ref_clk) disable iff (!resetn)
        !clock_input_select_pin && pll_ref_sel |=>
            pll_ref_clk == $past(crystal_in_pin) && core_clk_src == $past(pll_clk);
    endproperty
    a_pll_ref: assert property (p_pll_ref) else $error("PLL reference wrong.");

    property p_ctrl_drive;
        @(posedge ref_clk) disable iff (!resetn)
        emi_bus_active |=> ctrl_pin_oe == CTRL_ALL_ON && ctrl_pin_o == $past(emi_ctrl);
    endproperty
    a_ctrl_drive: assert property (p_ctrl_drive) else $error("Controls not driven.");

    property p_pull_follow;
        @(posedge ref_clk) disable iff (!resetn)
        1'b1 |=> addr_pin_pu == $past(port_a_pullup_enable_reg);
    endproperty
    a_pull_follow: assert property (p_pull_follow) else $error("Pull-up stale.");

    property p_port_in;
        @(posedge ref_clk) disable iff (!resetn)
        1'b1 |=> port_in == $past(addr_pin_i);
    endproperty
    a_port_in: assert property (p_port_in) else $error("Pin level lost.");

    // A pin handed to the port must not pull the others out of the address role.
    property p_addr_split;
        @(posedge ref_clk) disable iff (!resetn)
        port_sel == 6'h01 && emi_bus_active |=>
            addr_pin_oe[5:1] == 5'h1f && addr_pin_o[5:1] == $past(emi_addr[5:1]);
    endproperty
    a_addr_split: assert property (p_addr_split) else $error("Address role lost.");

endmodule : apcm_top

// [tb/apcm_ext_mem.sv]
module apcm_ext_mem
    import apcm_pkg::*;
(
    // Clock.
    input wire logic ref_clk,
    // Pin drive from the device.
    input wire logic [apcm_pkg::PIN_COUNT-1:0] pin_o,
    input wire logic [apcm_pkg::PIN_COUNT-1:0] pin_oe,
    input wire logic [apcm_pkg::PIN_COUNT-1:0] pin_pu,
    input wire logic bus_active,
    // Outside source commanded by the bench.
    input wire logic [apcm_pkg::PIN_COUNT-1:0] ext_en,
    input wire logic [apcm_pkg::PIN_COUNT-1:0] ext_val,
    // Resolved wire levels and the last address seen.
    output logic [apcm_pkg::PIN_COUNT-1:0] pin_level,
    output logic [apcm_pkg::PIN_COUNT-1:0] last_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    logic float_q = 1'b0;
    // An undriven pin without pull-up toggles so a stale value never passes.
    always @(posedge ref_clk) begin
        float_q <= ~float_q;
    end
    // Device drive wins, then the outside source, then the pull-up.
    assign pin_level = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pin_pu | {6{float_q}}));
    // The memory latches the address while the bus is active and fully driven.
    always @(posedge ref_clk) begin
        if (bus_active && pin_oe == 6'h3f) begin
            last_addr <= pin_level;
        end
    end
endmodule : apcm_ext_mem

// [tb/tb.sv]
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import apcm_pkg::*;
    logic ref_clk = 0, resetn = 0, emi_bus_active = 0, bus_idle_drive_bit = 0;
    logic [5:0] emi_addr = 6'h00, port_sel = 6'h00, port_dir = 6'h00, port_out = 6'h00;
    logic [5:0] ext_en = 6'h00, ext_val = 6'h00, pin_level, last_addr;
    logic [2:0] emi_ctrl = 3'h5;
    logic [13:8] pu_reg = 6'h3f;
    logic [3:0] clk_sel = 4'h0;
    logic [6:0] src = 7'h00;
    logic [4:0] cin = 5'h00;
    logic [5:0] port_in, addr_pin_o, addr_pin_oe, addr_pin_pu;
    logic [2:0] ctrl_pin_o, ctrl_pin_oe;
    logic clock_out_pin, clock_out_oe, core_clk_src, pll_ref_clk, osc_amp_en;
    int mismatches = 0, num_checks = 0;
    // The reference clock runs at 10 MHz.
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    apcm_top uut (.ref_clk(ref_clk), .resetn(resetn), .emi_addr(emi_addr), .emi_ctrl(emi_ctrl),
        .emi_bus_active(emi_bus_active), .bus_idle_drive_bit(bus_idle_drive_bit),
        .port_sel(port_sel), .port_dir(port_dir), .port_out(port_out),
        .port_a_pullup_enable_reg(pu_reg), .port_in(port_in), .addr_pin_i(pin_level),
        .addr_pin_o(addr_pin_o), .addr_pin_oe(addr_pin_oe), .addr_pin_pu(addr_pin_pu),
        .ctrl_pin_o(ctrl_pin_o), .ctrl_pin_oe(ctrl_pin_oe), .clock_out_select_reg(clk_sel),
        .master_system_clock(src[0]), .peripheral_bus_clock(src[1]), .osc_out(src[2]),
        .prescaler_clk(src[3]), .postscaler_clk(src[4]), .test_sig(src[6:5]),
        .clock_out_pin(clock_out_pin), .clock_out_oe(clock_out_oe),
        .clock_input_select_pin(cin[4]), .crystal_in_pin(cin[3]),
        .crystal_out_pin_i(cin[2]), .pll_ref_sel(cin[1]), .pll_clk(cin[0]),
        .osc_amp_en(osc_amp_en), .core_clk_src(core_clk_src), .pll_ref_clk(pll_ref_clk));
    apcm_ext_mem mem (.ref_clk(ref_clk), .pin_o(addr_pin_o), .pin_oe(addr_pin_oe),
        .pin_pu(addr_pin_pu), .bus_active(emi_bus_active), .ext_en(ext_en),
        .ext_val(ext_val), .pin_level(pin_level), .last_addr(last_addr));
    // Inputs change one nanosecond after the rising edge.
    task step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step
    // Prints the counts and the verdict, then ends the run.
    task summarize;
        $display("Checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    // Pins idle in reset with drivers off and pull-ups holding the wires high.
    task t_reset;
        `CHK(addr_pin_oe, 6'h00)
        `CHK(pin_level, 6'h3f)
        `CHK(ctrl_pin_oe, 3'h0)
        `CHK(clock_out_oe, 1'b0)
        `CHK(clock_out_pin, 1'b0)
        `CHK(ctrl_pin_o, 3'h7)
    endtask : t_reset
    // Address role by default even with port controls set, then idle policy.
    task t_addr;
        port_dir = 6'h3f;
        port_out = 6'h15;
        emi_bus_active = 1;
        emi_addr = 6'h2a;
        step(1);
        `CHK(addr_pin_oe, 6'h3f)
        `CHK(addr_pin_o, 6'h2a)
        step(1);
        `CHK(last_addr, 6'h2a)
        emi_bus_active = 0;
        step(1);
        `CHK({addr_pin_oe, ctrl_pin_oe}, 9'h000)
        bus_idle_drive_bit = 1;
        step(1);
        `CHK({addr_pin_oe, ctrl_pin_oe, ctrl_pin_o}, 12'hFFD)
    endtask : t_addr
    // Port role with mixed directions, then a single pin handed over.
    task t_port;
        port_sel = 6'h3f;
        port_dir = 6'h15;
        port_out = 6'h3f;
        ext_en = 6'h2a;
        ext_val = 6'h28;
        emi_bus_active = 1;
        step(1);
        `CHK(addr_pin_oe, 6'h15)
        `CHK(addr_pin_o & 6'h15, 6'h15)
        step(1);
        `CHK(port_in, 6'h3d)
        port_sel = 6'h01;
        port_dir = 6'h3f;
        emi_addr = 6'h00;
        ext_en = 6'h00;
        step(1);
        `CHK({addr_pin_oe, addr_pin_o}, 12'hFC1)
        pu_reg = 6'h3e;
        step(1);
        `CHK(addr_pin_pu, 6'h3e)
        pu_reg = 6'h3f;
    endtask : t_port
    // Every select code with two complementary source patterns.
    task t_clock_out_pin;
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 16; k++) begin
                src = p ? 7'h55 : 7'h2a;
                clk_sel = 4'(k);
                step(1);
                `CHK(clock_out_oe, 1'(k >= 1 && k <= 7))
                if (k >= 1 && k <= 7) `CHK(clock_out_pin, src[k-1])
                else `CHK(clock_out_pin, 1'b0)
            end
        end
    endtask : t_clock_out_pin
    // Input clock routing for both modes, direct and through the PLL.
    task automatic t_clkin;
        logic [6:0] tbl [6] = '{7'h52, 7'h64, 7'h22, 7'h29, 7'h59, 7'h1E};
        for (int i = 0; i < 6; i++) begin
            cin = tbl[i][6:2];
            step(1);
            `CHK({core_clk_src, pll_ref_clk}, tbl[i][1:0])
            `CHK(osc_amp_en, ~tbl[i][6])
        end
    endtask : t_clkin
    // A reset in mid-run turns drivers off at once.
    task t_rereset;
        emi_bus_active = 1;
        clk_sel = 4'h1;
        step(1);
        resetn = 0;
        #1;
        `CHK({addr_pin_oe, addr_pin_pu, clock_out_oe}, 13'h007E)
        step(1);
        resetn = 1;
        step(1);
        `CHK(clock_out_oe, 1'b1)
    endtask : t_rereset
    // Main sequence.
    initial begin
        step(3);
        t_reset();
        step(1);
        resetn = 1;
        step(1);
        t_addr();
        t_port();
        t_clock_out_pin();
        t_clkin();
        t_rereset();
        summarize();
    end
endmodule : tb
